// *** verilog/otd_pkg.sv ***
// Purpose: Shared constants and carrier types for the opacity threshold detector.
// Assumes: 50 MHz system clock; readings arrive as 0..99 with a one-cycle valid.
// Notes: Timing figures are held in their own unit; only the tick is converted to clocks here.
package otd_pkg;
    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned TICK_US = 1000;
    localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
    localparam int unsigned STRETCH_STEP_MS = 10;
    localparam int unsigned LOCK_HOLD_MS = 3000;
    localparam int unsigned MENU_HOLD_MS = 2000;
    localparam int unsigned REPEAT_MS = 250;
    localparam int unsigned FLASH_MS = 250;

    // ----------------------------------------------------------------
    // Value ranges and factory defaults
    // ----------------------------------------------------------------
    localparam logic [6:0] READ_MAX = 7'h63;
    localparam logic [6:0] THRESH_DEF = 7'h0F;
    localparam logic [3:0] HYST_MAX = 4'h9;
    localparam logic [3:0] HYST_DEF = 4'h2;
    localparam logic [3:0] STRETCH_MAX = 4'h9;
    localparam logic [3:0] STRETCH_DEF = 4'h0;
    localparam logic [6:0] OFFSET_DEF = 7'h00;

    // ----------------------------------------------------------------
    // Enumerations
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        INT_LOW,
        INT_MED,
        INT_HIGH
    } otd_intensity_type;

    typedef enum logic [2:0] {
        ITEM_RUN,
        ITEM_THRESH,
        ITEM_INTENSITY,
        ITEM_HYST,
        ITEM_POLARITY,
        ITEM_STRETCH,
        ITEM_ZERO
    } otd_item_type;

    // Display status shown to the segment driver
    typedef enum logic [1:0] {
        SHOW_NORMAL,
        SHOW_KEY_LOCK,
        SHOW_FAR_LOCK,
        SHOW_ZERO_FLASH
    } otd_show_type;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [6:0] thresh;
        logic [3:0] hyst;
        otd_intensity_type intensity;
        logic closedMode;
        logic [3:0] stretch;
        logic [6:0] offset;
    } otd_settings_type;

    localparam otd_settings_type SETTINGS_DEF = '{
        thresh: THRESH_DEF,
        hyst: HYST_DEF,
        intensity: INT_MED,
        closedMode: 1'b0,
        stretch: STRETCH_DEF,
        offset: OFFSET_DEF
    };

    typedef struct packed {
        otd_item_type item;
        otd_show_type show;
        logic [6:0] value;
        logic [1:0] decimalPoints;
        logic keyLocked;
    } otd_display_type;
endpackage : otd_pkg

// *** verilog/otd_key_timer.sv ***
// Purpose: Synchronises one key, reports press, release and long hold.
// Assumes: Key input is a raw pin, high while pressed; tick is a 1 ms pulse.
// Notes: Bounce filtering is left to the hold counter granularity.
`timescale 1ns/1ps
module otd_key_timer #(
    parameter int unsigned HOLD_MS = 2000,  // Long hold threshold
    parameter int unsigned REPEAT_MS = 250  // Auto-repeat period while held
) (
    input wire logic clk,            // System clock
    input wire logic reset_n,        // Async reset, active low
    input wire logic msTick,         // 1 ms enable pulse
    input wire logic keyPin,         // Raw key pin, high pressed
    output logic keyLevel,           // Synchronised key level
    output logic keyRelease,         // Pulse on release
    output logic keyHold,            // Pulse once when hold time reached
    output logic keyRepeat           // Pulse every repeat period after hold
);
    // ----------------------------------------------------------------
    // Synchroniser and counters
    // ----------------------------------------------------------------
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;
    logic [15:0] held_ff;
    logic [15:0] nxt_held;
    logic [15:0] rep_ff;
    logic [15:0] nxt_rep;
    wire atHold = (held_ff == 16'(HOLD_MS));
    wire pastHold = (held_ff > 16'(HOLD_MS));
    wire repDue = (rep_ff == 16'(REPEAT_MS));

    // Two stages before anyone looks at the pin
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            meta_ff <= keyPin;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    // Hold count saturates one past the threshold so the hold pulse fires once
    assign nxt_held = !sync_ff ? 16'h0000 :
                      (msTick && !pastHold) ? held_ff + 16'h0001 : held_ff;
    assign nxt_rep = (!sync_ff || repDue) ? 16'h0000 :
                     (msTick && pastHold) ? rep_ff + 16'h0001 : rep_ff;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            held_ff <= 16'h0000;
            rep_ff <= 16'h0000;
        end else begin
            held_ff <= nxt_held;
            rep_ff <= nxt_rep;
        end
    end

    // A release that ends a long hold is not a tap, so a menu entry stays put
    assign keyLevel = sync_ff;
    assign keyRelease = prev_ff && !sync_ff && !pastHold;
    assign keyHold = msTick && sync_ff && atHold;
    assign keyRepeat = repDue && sync_ff;
endmodule : otd_key_timer

// *** verilog/otd_detector.sv ***
// Purpose: Decision, settings and key menu logic of an opacity sensor.
// Assumes: Reading 0..99 arrives with a one-cycle valid; keys are raw pins.
// Notes: Settings persistence is by an external store through load/save ports.
`timescale 1ns/1ps
// How it works
// - Detect when corrected reading reaches or exceeds threshold; red LED and output on.
// - Undetect only when reading falls to threshold minus hysteresis.
// - Hysteresis 0..9, right key press steps it in its menu item.
// - Factory hysteresis is 2.
// - Factory threshold is 15.
// - Right key steps threshold, repeats while held, 99 wraps to 00.
// - Three intensity levels cycled by right key, medium by default.
// - Decimal points show intensity: none, one or two lit.
// - Normally open: output inactive undetected, active detecting.
// - Normally closed inverts output; right key toggles configuration.
// - Factory configuration is normally open.
// - Stretch selectable 0..90 ms in 10 ms steps, codes 0..9.
// - Output stays active while detecting; stretch is only a minimum.
// - Holding right key in zero item captures offset, subtracts it, flashes it.
// - Eight-bit analog code tracks reading from zero to full scale.
// - Remote lock ignores keys; a press shows the remote lock indication.
// - Left hold enters and leaves menu; left press advances items.
// - Settings go to non-volatile store and are restored at start.
// - Both keys held 3 s toggle key lockout; locked presses show it.
module otd_detector #(
    parameter int unsigned TICK_CYC = otd_pkg::TICK_CYC,   // Clocks per ms tick
    parameter int unsigned LOCK_MS = otd_pkg::LOCK_HOLD_MS, // Both-key hold time
    parameter int unsigned MENU_MS = otd_pkg::MENU_HOLD_MS  // Left key hold time
) (
    input wire logic clk,                                   // 50 MHz clock
    input wire logic reset_n,                               // Async reset, active low
    input wire logic [6:0] rawReading,                      // Reading 0..99
    input wire logic rawValid,                              // New reading pulse
    input wire logic leftKeyPin,                            // Menu key pin, high pressed
    input wire logic rightKeyPin,                           // Change key pin, high pressed
    input wire logic remoteLockPin,                         // Remote lock pin, high locks
    input wire logic storeValid,                            // Stored settings valid
    input wire otd_pkg::otd_settings_type storeData,        // Settings read from store
    output logic detectOut,                                 // Discrete output, active high when normally open, active low when normally closed
    output logic redLed,                                    // Detect indicator
    output logic progLed,                                   // Menu indicator
    output logic [7:0] analogCode,                          // Analog output code
    output otd_pkg::otd_settings_type settings,             // Live settings
    output logic saveReq,                                   // Pulse: write settings to store
    output otd_pkg::otd_display_type display                // Display content
);
    // ----------------------------------------------------------------
    // Millisecond tick divider
    // ----------------------------------------------------------------
    logic [15:0] div_ff;
    wire msTick = (div_ff == 16'(TICK_CYC - 1));

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_ff <= 16'h0000;
        end else begin
            div_ff <= msTick ? 16'h0000 : div_ff + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // Key front ends and remote lock synchroniser
    // ----------------------------------------------------------------
    logic leftLevel, leftRelease, leftHold;
    logic rightLevel, rightRelease, rightHold, rightRepeat;
    logic remMeta_ff, remSync_ff;

    otd_key_timer #(.HOLD_MS(MENU_MS), .REPEAT_MS(otd_pkg::REPEAT_MS)) uLeft (
        .clk(clk),
        .reset_n(reset_n),
        .msTick(msTick),
        .keyPin(leftKeyPin),
        .keyLevel(leftLevel),
        .keyRelease(leftRelease),
        .keyHold(leftHold),
        .keyRepeat()
    );

    otd_key_timer #(.HOLD_MS(MENU_MS), .REPEAT_MS(otd_pkg::REPEAT_MS)) uRight (
        .clk(clk),
        .reset_n(reset_n),
        .msTick(msTick),
        .keyPin(rightKeyPin),
        .keyLevel(rightLevel),
        .keyRelease(rightRelease),
        .keyHold(rightHold),
        .keyRepeat(rightRepeat)
    );

    // Open line is pulled low outside, so low reads as unlocked
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            remMeta_ff <= 1'b0;
            remSync_ff <= 1'b0;
        end else begin
            remMeta_ff <= remoteLockPin;
            remSync_ff <= remMeta_ff;
        end
    end

    // ----------------------------------------------------------------
    // Lockouts
    // ----------------------------------------------------------------
    logic keyLock_ff;
    logic [15:0] both_ff;
    logic bothArmed_ff;
    wire bothHeld = leftLevel && rightLevel;
    wire bothDone = bothHeld && msTick && (both_ff == 16'(LOCK_MS - 1)) && bothArmed_ff;
    wire remoteLocked = remSync_ff;
    // A release after a two-key gesture reaches the lock time does not count as a single press
    wire keysFree = !remoteLocked && !keyLock_ff && !bothHeld && bothArmed_ff;
    wire anyRelease = leftRelease || rightRelease;

    // Both keys held for the lock time toggle key lockout once per gesture
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            both_ff <= 16'h0000;
            bothArmed_ff <= 1'b1;
            keyLock_ff <= 1'b0;
        end else begin
            both_ff <= !bothHeld ? 16'h0000 : (msTick ? both_ff + 16'h0001 : both_ff);
            bothArmed_ff <= (!leftLevel && !rightLevel) ? 1'b1 : (bothDone ? 1'b0 : bothArmed_ff);
            keyLock_ff <= (bothDone && !remoteLocked) ? !keyLock_ff : keyLock_ff;
        end
    end

    // ----------------------------------------------------------------
    // Menu and settings
    // ----------------------------------------------------------------
    otd_pkg::otd_item_type item_ff, nxt_item;
    otd_pkg::otd_settings_type set_ff, nxt_set;
    logic loaded_ff;
    logic [6:0] corr_ff;
    logic saveReq_ff;
    logic zeroFlash_ff;
    wire inMenu = (item_ff != otd_pkg::ITEM_RUN);
    wire rightStep = keysFree && (rightRelease || rightRepeat);
    wire rightTap = keysFree && rightRelease;

    // Item sequencing on left key
    always_comb begin
        nxt_item = item_ff;
        if (keysFree && leftHold) begin
            nxt_item = inMenu ? otd_pkg::ITEM_RUN : otd_pkg::ITEM_THRESH;
        end else if (keysFree && leftRelease && inMenu) begin
            case (item_ff)
                otd_pkg::ITEM_THRESH: nxt_item = otd_pkg::ITEM_INTENSITY;
                otd_pkg::ITEM_INTENSITY: nxt_item = otd_pkg::ITEM_HYST;
                otd_pkg::ITEM_HYST: nxt_item = otd_pkg::ITEM_POLARITY;
                otd_pkg::ITEM_POLARITY: nxt_item = otd_pkg::ITEM_STRETCH;
                otd_pkg::ITEM_STRETCH: nxt_item = otd_pkg::ITEM_ZERO;
                otd_pkg::ITEM_ZERO: nxt_item = otd_pkg::ITEM_THRESH;
                default: nxt_item = otd_pkg::ITEM_RUN;
            endcase
        end
    end

    // Setting changes on right key for the item shown
    always_comb begin
        nxt_set = set_ff;
        case (item_ff)
            otd_pkg::ITEM_THRESH: begin
                if (rightStep) begin
                    nxt_set.thresh = (set_ff.thresh >= otd_pkg::READ_MAX) ? 7'h00 :
                                     set_ff.thresh + 7'h01;
                end
            end
            otd_pkg::ITEM_INTENSITY: begin
                if (rightTap) begin
                    case (set_ff.intensity)
                        otd_pkg::INT_LOW: nxt_set.intensity = otd_pkg::INT_MED;
                        otd_pkg::INT_MED: nxt_set.intensity = otd_pkg::INT_HIGH;
                        default: nxt_set.intensity = otd_pkg::INT_LOW;
                    endcase
                end
            end
            otd_pkg::ITEM_HYST: begin
                if (rightTap) begin
                    nxt_set.hyst = (set_ff.hyst >= otd_pkg::HYST_MAX) ? 4'h0 :
                                   set_ff.hyst + 4'h1;
                end
            end
            otd_pkg::ITEM_POLARITY: begin
                if (rightTap) begin
                    nxt_set.closedMode = !set_ff.closedMode;
                end
            end
            otd_pkg::ITEM_STRETCH: begin
                if (rightTap) begin
                    nxt_set.stretch = (set_ff.stretch >= otd_pkg::STRETCH_MAX) ? 4'h0 :
                                      set_ff.stretch + 4'h1;
                end
            end
            otd_pkg::ITEM_ZERO: begin
                if (keysFree && rightHold && rawValid) begin
                    nxt_set.offset = rawReading;
                end
            end
            default: nxt_set = set_ff;
        endcase
    end

    // Factory defaults at reset, then stored values restored once
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            item_ff <= otd_pkg::ITEM_RUN;
            set_ff <= otd_pkg::SETTINGS_DEF;
            loaded_ff <= 1'b0;
            saveReq_ff <= 1'b0;
        end else begin
            item_ff <= nxt_item;
            loaded_ff <= loaded_ff || storeValid;
            set_ff <= (!loaded_ff && storeValid) ? storeData : nxt_set;
            saveReq_ff <= loaded_ff && (nxt_set != set_ff);
        end
    end

    // ----------------------------------------------------------------
    // Offset correction and threshold decision
    // ----------------------------------------------------------------
    logic detect_ff;
    logic corrValid_ff;
    wire [6:0] corrNow = (rawReading > set_ff.offset) ? rawReading - set_ff.offset : 7'h00;
    wire [7:0] lowEdge = {1'b0, set_ff.thresh} - {4'h0, set_ff.hyst};
    wire atOrAbove = (corr_ff >= set_ff.thresh);
    // Hysteresis below zero leaves only an exact zero able to release
    wire atOrBelow = lowEdge[7] ? (corr_ff == 7'h00) : ({1'b0, corr_ff} <= lowEdge);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            corr_ff <= 7'h00;
            corrValid_ff <= 1'b0;
            detect_ff <= 1'b0;
        end else begin
            corrValid_ff <= rawValid;
            corr_ff <= rawValid ? corrNow : corr_ff;
            if (corrValid_ff && !detect_ff && atOrAbove) begin
                detect_ff <= 1'b1;
            end else if (corrValid_ff && detect_ff && atOrBelow) begin
                detect_ff <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Minimum-active stretch
    // ----------------------------------------------------------------
    logic detectPrev_ff;
    logic [6:0] stretch_ff;
    wire detectRise = detect_ff && !detectPrev_ff;
    wire [6:0] stretchLoad = 7'(set_ff.stretch * otd_pkg::STRETCH_STEP_MS);

    // Timer counts ms down from the rise; output ends at the later of the two
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            detectPrev_ff <= 1'b0;
            stretch_ff <= 7'h00;
        end else begin
            detectPrev_ff <= detect_ff;
            if (detectRise) begin
                stretch_ff <= stretchLoad;
            end else if (msTick && stretch_ff != 7'h00) begin
                stretch_ff <= stretch_ff - 7'h01;
            end
        end
    end

    wire activeLevel = detect_ff || (stretch_ff != 7'h00);

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    logic detectOut_ff;
    logic [7:0] analog_ff;
    logic [1:0] show_ff;
    logic [7:0] flashCnt_ff;

    // Show lock indications on a press, zero flash while capturing
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            detectOut_ff <= 1'b0;
            analog_ff <= 8'h00;
            show_ff <= otd_pkg::SHOW_NORMAL;
            zeroFlash_ff <= 1'b0;
            flashCnt_ff <= 8'h00;
        end else begin
            detectOut_ff <= activeLevel ^ set_ff.closedMode;
            // Scale 0..99 to 0..255 full scale
            analog_ff <= 8'((16'(corr_ff) * 16'h00FF) / 16'h0063);
            if (msTick) begin
                flashCnt_ff <= (flashCnt_ff == 8'(otd_pkg::FLASH_MS - 1)) ? 8'h00 :
                               flashCnt_ff + 8'h01;
            end
            if (msTick && flashCnt_ff == 8'h00) begin
                zeroFlash_ff <= (item_ff == otd_pkg::ITEM_ZERO) && rightLevel && !zeroFlash_ff;
            end
            if (remoteLocked && (leftLevel || rightLevel)) begin
                show_ff <= otd_pkg::SHOW_FAR_LOCK;
            end else if (keyLock_ff && (leftLevel || rightLevel) && !bothHeld) begin
                show_ff <= otd_pkg::SHOW_KEY_LOCK;
            end else if (item_ff == otd_pkg::ITEM_ZERO && rightLevel) begin
                show_ff <= otd_pkg::SHOW_ZERO_FLASH;
            end else if (anyRelease || !(leftLevel || rightLevel)) begin
                show_ff <= otd_pkg::SHOW_NORMAL;
            end
        end
    end

    wire [6:0] itemValue = (item_ff == otd_pkg::ITEM_THRESH) ? set_ff.thresh :
                           (item_ff == otd_pkg::ITEM_INTENSITY) ? 7'(set_ff.intensity) + 7'h01 :
                           (item_ff == otd_pkg::ITEM_HYST) ? 7'(set_ff.hyst) :
                           (item_ff == otd_pkg::ITEM_POLARITY) ? 7'(set_ff.closedMode) :
                           (item_ff == otd_pkg::ITEM_STRETCH) ? 7'(set_ff.stretch) :
                           (item_ff == otd_pkg::ITEM_ZERO) ?
                               (zeroFlash_ff ? set_ff.offset : 7'h00) : corr_ff;

    assign detectOut = detectOut_ff;
    assign redLed = detect_ff;
    assign progLed = inMenu;
    assign analogCode = analog_ff;
    assign settings = set_ff;
    assign saveReq = saveReq_ff;
    assign display.item = item_ff;
    assign display.show = otd_pkg::otd_show_type'(show_ff);
    assign display.value = itemValue;
    assign display.decimalPoints = 2'(set_ff.intensity);
    assign display.keyLocked = keyLock_ff;
endmodule : otd_detector

// *** verification/otd_plc_model.sv ***
// Purpose: Controller model that scans the discrete and analog outputs.
// Assumes: Slow scan, like a polled input card.
// Notes: Lock line is driven high to lock; an open line reads low.
`timescale 1ns/1ps
module otd_plc_model #(
    parameter int unsigned POLL_CYC = 7 // Clocks between scans
) (
    input wire logic clk, // Clock
    input wire logic lockReq, // Bench asks for lock
    input wire logic detectOut, // Discrete output
    input wire logic [7:0] analogCode, // Analog code
    output logic remoteLockPin, // Remote lock line
    output logic [7:0] seenCode, // Last scanned code
    output logic seenDetect // Last scanned discrete output
);
    int unsigned pollCnt = 0;
    // Open line counts as unlocked, so only a lock request drives it high
    assign remoteLockPin = lockReq;
    // Slow scan can miss short pulses; the stretch setting exists for this
    always @(posedge clk) begin
        pollCnt <= (pollCnt == POLL_CYC - 1) ? 0 : pollCnt + 1;
        if (pollCnt == 0) begin
            seenCode <= analogCode;
            seenDetect <= detectOut;
        end
    end
endmodule : otd_plc_model

// *** verification/otd_detector_chk.sv ***
// Purpose: Port checks for the opacity threshold detector.
// Assumes: redLed two cycles and detectOut three after a reading.
// Notes: Offset assumed steady across a check window.
`timescale 1ns/1ps
module otd_detector_chk (
    input wire logic clk, // Clock
    input wire logic reset_n, // Reset, active low
    input wire logic [6:0] rawReading, // Reading
    input wire logic rawValid, // Reading strobe
    input wire logic remoteLockPin, // Remote lock
    input wire logic storeValid, // Store load
    input wire logic detectOut, // Discrete output
    input wire logic redLed, // Detect state
    input wire logic [7:0] analogCode, // Analog code
    input wire otd_pkg::otd_settings_type settings, // Settings
    input wire otd_pkg::otd_display_type display // Display
);
    // Widened corrected reading, so sums cannot wrap
    wire [7:0] corr = {1'b0, rawReading} - {1'b0, settings.offset};
    wire corrOk = rawReading >= settings.offset;
    wire [7:0] lim = {1'b0, settings.thresh};
    wire [7:0] hyst = {4'h0, settings.hyst};
    wire [15:0] scaled = {8'h00, corr} * 16'h00FF / 16'h0063;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_detect_on: assert property (rawValid && corrOk && corr >= lim |-> ##2 redLed)
        else $error("red LED not set at threshold");
    a_detect_off: assert property (rawValid && corrOk && corr < lim && corr + hyst <= lim
        |-> ##2 !redLed) else $error("red LED not released");
    a_hyst_band: assert property (rawValid && corrOk && corr < lim && corr + hyst > lim
        ##1 !rawValid |=> $stable(redLed)) else $error("detect left inside band");
    a_out_active: assert property ($past(redLed) && $stable(settings.closedMode)
        |-> detectOut != settings.closedMode) else $error("output not active on detect");
    a_out_idle: assert property (!$past(redLed) && settings.stretch == 4'h0
        && $stable(settings) |-> detectOut == settings.closedMode) else $error("output idle");
    a_analog_code: assert property (rawValid && corrOk |-> ##2 analogCode == scaled[7:0])
        else $error("analog code wrong");
    a_hyst_range: assert property (settings.hyst <= otd_pkg::HYST_MAX)
        else $error("hysteresis out of range");
    a_thresh_range: assert property (settings.thresh <= otd_pkg::READ_MAX)
        else $error("threshold out of range");
    a_dots_show: assert property ($stable(settings.intensity) ##1 $stable(settings.intensity)
        |-> display.decimalPoints == 2'(settings.intensity)) else $error("dots wrong");
    a_far_lock: assert property (remoteLockPin [*4] ##0 !storeValid |=> $stable(settings))
        else $error("setting changed under remote lock");
endmodule : otd_detector_chk
bind otd_detector otd_detector_chk chk (.clk(clk), .reset_n(reset_n), .rawReading(rawReading),
    .rawValid(rawValid), .remoteLockPin(remoteLockPin), .storeValid(storeValid),
    .detectOut(detectOut), .redLed(redLed), .analogCode(analogCode), .settings(settings),
    .display(display));

// *** verification/test_opacity_threshold_detector.sv ***
// Purpose: Directed bench for the opacity threshold detector.
// Assumes: Short tick and hold times; store never valid.
// Notes: Inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
module test_opacity_threshold_detector;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [6:0] rawReading = 7'h00;
    logic rawValid = 1'b0;
    logic leftKeyPin = 1'b0;
    logic rightKeyPin = 1'b0;
    logic lockReq = 1'b0;
    logic remoteLockPin, detectOut, redLed, progLed, seenDetect;
    logic [7:0] analogCode, seenCode;
    otd_pkg::otd_settings_type settings;
    otd_pkg::otd_display_type display;
    int n_fail = 0;
    int n_tests = 0;
    // 50 MHz clock
    always #10 clk = ~clk;
    otd_detector #(.TICK_CYC(10), .LOCK_MS(5), .MENU_MS(5)) dut (.clk(clk), .reset_n(reset_n),
        .rawReading(rawReading), .rawValid(rawValid), .leftKeyPin(leftKeyPin),
        .rightKeyPin(rightKeyPin), .remoteLockPin(remoteLockPin), .storeValid(1'b0),
        .storeData(otd_pkg::SETTINGS_DEF), .detectOut(detectOut), .redLed(redLed),
        .progLed(progLed), .analogCode(analogCode), .settings(settings), .saveReq(),
        .display(display));
    otd_plc_model plc (.clk(clk), .lockReq(lockReq), .detectOut(detectOut),
        .analogCode(analogCode), .remoteLockPin(remoteLockPin), .seenCode(seenCode),
        .seenDetect(seenDetect));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim
    // One reading, then wait until detectOut has settled
    task automatic send(input logic [6:0] val);
        @(posedge clk);
        #1 rawReading = val;
        rawValid = 1'b1;
        @(posedge clk);
        #1 rawValid = 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask : send
    // Held past the menu hold time, so an ignored key really is ignored
    task automatic press(input bit right, input logic [1:0] expShow);
        int i;
        rightKeyPin = right;
        leftKeyPin = !right;
        for (i = 0; i < 8 && display.show !== expShow; i++) begin
            @(posedge clk);
            #1;
        end
        chk("show", {6'h00, expShow}, {6'h00, display.show});
        if (i == 8) begin
            end_sim();
        end
        repeat (80) @(posedge clk);
        #1 rightKeyPin = 1'b0;
        leftKeyPin = 1'b0;
        repeat (20) @(posedge clk);
        #1;
    endtask : press
    // Defaults, threshold edges, hysteresis band, analog code, remote lock
    initial begin
        repeat (20) @(posedge clk);
        #1 reset_n = 1'b1;
        @(posedge clk);
        #1;
        chk("thresh", 8'h0F, {1'b0, settings.thresh});
        chk("hyst", 8'h02, {4'h0, settings.hyst});
        chk("closed", 8'h00, {7'h00, settings.closedMode});
        chk("intensity", 8'h01, {6'h00, settings.intensity});
        chk("dots", 8'h01, {6'h00, display.decimalPoints});
        send(7'h0E);
        chk("out below", 8'h00, {7'h00, detectOut});
        send(7'h0F);
        chk("red at", 8'h01, {7'h00, redLed});
        chk("out at", 8'h01, {7'h00, detectOut});
        chk("analog", 8'h26, analogCode);
        send(7'h0E);
        chk("red band", 8'h01, {7'h00, redLed});
        send(7'h0D);
        chk("red off", 8'h00, {7'h00, redLed});
        chk("out off", 8'h00, {7'h00, detectOut});
        send(7'h63);
        repeat (10) @(posedge clk);
        #1;
        chk("plc code", 8'hFF, seenCode);
        chk("plc out", 8'h01, {7'h00, seenDetect});
        lockReq = 1'b1;
        press(1'b1, otd_pkg::SHOW_FAR_LOCK);
        press(1'b0, otd_pkg::SHOW_FAR_LOCK);
        chk("thresh locked", 8'h0F, {1'b0, settings.thresh});
        chk("menu locked", 8'h00, {7'h00, progLed});
        lockReq = 1'b0;
        press(1'b0, otd_pkg::SHOW_NORMAL);
        chk("menu item", 8'h01, {5'h00, display.item});
        end_sim();
    end
endmodule : test_opacity_threshold_detector
